// ---- rtl/timer_event_defs.svh ----
// timer event flag block constants
`ifndef TIMER_EVENT_DEFS_SVH
`define TIMER_EVENT_DEFS_SVH
`define CNT_W        16
`define NUM_CH       2
`define CNT_MAX      16'hFFFF
`define CNT_ZERO     16'h0000
`define EDGE_OFF     2'h0
`define EDGE_RISE    2'h1
`define EDGE_FALL    2'h2
`define EDGE_BOTH    2'h3
`define CTRL_RST     1'h0
`endif

// ---- rtl/timer_event_pkg.sv ----
// timer event flag block types
`include "timer_event_defs.svh"
package timer_event_pkg;
    typedef enum logic [3:0] {
        CH_CAPTURE = 4'h1,
        CH_COMPARE = 4'h2,
        CH_EPWM    = 4'h4,
        CH_CENTER_ALIGNED_PWM    = 4'h8
    } ch_mode_t;
    typedef enum logic [1:0] {
        CLR_IDLE  = 2'h1,
        CLR_ARMED = 2'h2
    } clr_state_t;
endpackage

// ---- rtl/flag_clear_cell.sv ----
// one event flag with read-then-write-zero clearing
`include "timer_event_defs.svh"
module flag_clear_cell
    import timer_event_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // event and software access
    input  wire logic set_i,
    input  wire logic rd_i,
    input  wire logic wr_i,
    input  wire logic wr_data_i,
    // flag
    output logic      flag_o
);
    clr_state_t state_reg;
    clr_state_t state_next;
    logic       flag_next;
    wire        do_clear = wr_i & ~wr_data_i & (state_reg == CLR_ARMED);

    // a new event drops the armed state so the pending zero write is void
    always_comb begin
        state_next = state_reg;
        flag_next  = flag_o;
        unique case (state_reg)
            CLR_IDLE: begin
                if (rd_i & flag_o & ~set_i) begin
                    state_next = CLR_ARMED;
                end
            end
            CLR_ARMED: begin
                if (set_i) begin
                    state_next = CLR_IDLE;
                end else if (wr_i) begin
                    state_next = CLR_IDLE;
                end
            end
        endcase
        if (set_i) begin
            flag_next = 1'b1;
        end else if (do_clear) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= CLR_IDLE;
            flag_o    <= 1'b0;
        end else begin
            state_reg <= state_next;
            flag_o    <= flag_next;
        end
    end

    a_flag_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        set_i |=> flag_o)
        else $error("flag lost an event");
    a_flag_no_blind_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg == CLR_IDLE) && !set_i && flag_o |=> flag_o)
        else $error("flag cleared without qualifying read");
    a_flag_two_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_i && flag_o && !set_i && (state_reg == CLR_IDLE) ##1 wr_i && !wr_data_i && !set_i |=> !flag_o)
        else $error("read then zero write failed to clear");
endmodule

// ---- rtl/timer_event_flag_irq.sv ----
// counter, event flags and gated interrupt requests of a two-channel timer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`include "timer_event_defs.svh"
module timer_event_flag_irq
    import timer_event_pkg::*;
#(
    parameter int CNT_W  = `CNT_W,
    parameter int NUM_CH = `NUM_CH
) (
    // clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_n_i,
    // module control
    input  wire logic                    count_enable_i,
    input  wire logic                    center_align_select_i,
    input  wire logic                    overflow_irq_enable_i,
    input  wire logic [CNT_W-1:0]        modulo_i,
    input  wire logic                    background_debug_state_i,
    // channel configuration
    input  wire logic [NUM_CH-1:0][3:0]  ch_mode_i,
    input  wire logic [NUM_CH-1:0]       edge_select_high_bit_i,
    input  wire logic [NUM_CH-1:0]       edge_select_low_bit_i,
    input  wire logic [NUM_CH-1:0]       channel_irq_enable_i,
    input  wire logic [NUM_CH-1:0][CNT_W-1:0] ch_value_i,
    input  wire logic [NUM_CH-1:0]       ch_pin_i,
    // flag access
    input  wire logic                    ovf_rd_i,
    input  wire logic                    ovf_wr_i,
    input  wire logic                    ovf_wr_data_i,
    input  wire logic [NUM_CH-1:0]       ch_rd_i,
    input  wire logic [NUM_CH-1:0]       ch_wr_i,
    input  wire logic [NUM_CH-1:0]       ch_wr_data_i,
    // status and requests
    output logic [CNT_W-1:0]             count_o,
    output logic                         count_down_o,
    output logic                         overflow_flag_o,
    output logic [NUM_CH-1:0]            channel_event_flag_o,
    output logic [NUM_CH-1:0][CNT_W-1:0] capture_o,
    output logic                         overflow_irq_o,
    output logic [NUM_CH-1:0]            channel_irq_o
);
    // ------------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------------
    logic             ctrl_run_reg;
    logic [CNT_W-1:0] count_next;
    logic             down_next;
    logic             ovf_event;
    wire              advance   = ctrl_run_reg & ~background_debug_state_i;
    wire              mod_free  = (modulo_i == `CNT_ZERO);
    wire [CNT_W-1:0]  term      = mod_free ? `CNT_MAX : modulo_i;
    wire              at_term   = (count_o == term);
    wire              at_zero   = (count_o == `CNT_ZERO);

    // control reset value only; gating is captured after release
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_run_reg <= `CTRL_RST;
        end else begin
            ctrl_run_reg <= count_enable_i;
        end
    end

    always_comb begin
        count_next = count_o;
        down_next  = count_down_o;
        ovf_event  = 1'b0;
        if (advance) begin
            if (!center_align_select_i) begin
                down_next = 1'b0;
                if (at_term) begin
                    count_next = `CNT_ZERO;
                    ovf_event  = 1'b1;
                end else begin
                    count_next = count_o + 1'b1;
                end
            end else if (!count_down_o) begin
                if (at_term) begin
                    down_next  = 1'b1;
                    count_next = count_o - 1'b1;
                    ovf_event  = 1'b1;
                end else begin
                    count_next = count_o + 1'b1;
                end
            end else if (at_zero) begin
                down_next  = 1'b0;
                count_next = count_o + 1'b1;
            end else begin
                count_next = count_o - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o      <= `CNT_ZERO;
            count_down_o <= 1'b0;
        end else begin
            count_o      <= count_next;
            count_down_o <= down_next;
        end
    end

    flag_clear_cell u_ovf_flag (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .set_i      (ovf_event),
        .rd_i       (ovf_rd_i),
        .wr_i       (ovf_wr_i),
        .wr_data_i  (ovf_wr_data_i),
        .flag_o     (overflow_flag_o)
    );

    assign overflow_irq_o = overflow_flag_o & overflow_irq_enable_i;

    // ------------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------------
    // match is checked only when the counter moves, so a frozen count
    // does not keep re-raising the flag
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic pin_meta_reg;
            logic pin_sync_reg;
            logic pin_prev_reg;
            logic [CNT_W-1:0] cap_reg;
            wire [1:0] esel  = {edge_select_high_bit_i[g], edge_select_low_bit_i[g]};
            wire rise        = pin_sync_reg & ~pin_prev_reg;
            wire fall        = ~pin_sync_reg & pin_prev_reg;
            wire edge_hit    = ((esel == `EDGE_RISE) & rise) | ((esel == `EDGE_FALL) & fall)
                             | ((esel == `EDGE_BOTH) & (rise | fall));
            wire is_cap      = (ch_mode_i[g] == CH_CAPTURE);
            wire cap_evt     = is_cap & edge_hit;
            wire match       = advance & (count_o == ch_value_i[g]);
            wire cmp_evt     = match & ((ch_mode_i[g] == CH_COMPARE) | (ch_mode_i[g] == CH_EPWM));
            wire center_aligned_pwm_evt    = match & (ch_mode_i[g] == CH_CENTER_ALIGNED_PWM) & center_align_select_i;
            wire ch_evt      = cap_evt | cmp_evt | center_aligned_pwm_evt;

            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pin_meta_reg <= 1'b0;
                    pin_sync_reg <= 1'b0;
                    pin_prev_reg <= 1'b0;
                    cap_reg      <= `CNT_ZERO;
                end else begin
                    pin_meta_reg <= ch_pin_i[g];
                    pin_sync_reg <= pin_meta_reg;
                    pin_prev_reg <= pin_sync_reg;
                    if (cap_evt) begin
                        cap_reg <= count_o;
                    end
                end
            end

            assign capture_o[g] = cap_reg;

            flag_clear_cell u_ch_flag (
                .core_clk_i (core_clk_i),
                .rst_n_i    (rst_n_i),
                .set_i      (ch_evt),
                .rd_i       (ch_rd_i[g]),
                .wr_i       (ch_wr_i[g]),
                .wr_data_i  (ch_wr_data_i[g]),
                .flag_o     (channel_event_flag_o[g])
            );

            assign channel_irq_o[g] = channel_event_flag_o[g] & channel_irq_enable_i[g];

            a_ch_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                channel_irq_o[g] == (channel_event_flag_o[g] && channel_irq_enable_i[g]))
                else $error("channel request not a level of flag and enable");
            a_ch_cap_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                cap_evt |=> channel_event_flag_o[g] && (capture_o[g] == $past(count_o)))
                else $error("capture did not set flag or latch count");
            a_ch_edge_none: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                is_cap && (esel == `EDGE_OFF) |=> !$rose(channel_event_flag_o[g]))
                else $error("capture with edges off");
            a_ch_cmp_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                advance && (ch_mode_i[g] == CH_COMPARE) && (count_o == ch_value_i[g])
                |=> channel_event_flag_o[g])
                else $error("compare match missed");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence s_edge_wrap;
        advance && !center_align_select_i && at_term;
    endsequence
    sequence s_turn_down;
        advance && center_align_select_i && !count_down_o && at_term;
    endsequence

    a_ovf_edge_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_edge_wrap |=> (count_o == `CNT_ZERO) && overflow_flag_o)
        else $error("wrap did not zero counter and set overflow");
    a_ovf_center_turn: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_turn_down |=> count_down_o && overflow_flag_o)
        else $error("turn at modulo did not set overflow");
    a_ovf_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        overflow_irq_o == (overflow_flag_o && overflow_irq_enable_i))
        else $error("overflow request not gated");
    a_count_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !advance |=> $stable(count_o))
        else $error("counter moved while stopped");
endmodule

// ---- tb/irq_service_model.sv ----
// software side that services the overflow request by read then zero write
module irq_service_model (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // request and permission
    input  wire logic serve_i,
    input  wire logic irq_i,
    // flag access
    output logic      rd_o,
    output logic      wr_o,
    output logic      wr_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        wr_data_o = 1'b1;
        forever begin
            @(posedge core_clk_i);
            #1;
            if (rst_n_i && serve_i && irq_i === 1'b1) begin
                rd_o = 1'b1;
                @(posedge core_clk_i);
                #1;
                rd_o = 1'b0;
                wr_o = 1'b1;
                wr_data_o = 1'b0;
                @(posedge core_clk_i);
                #1;
                wr_o = 1'b0;
                // data line not held after the write
                wr_data_o = 1'b1;
                @(posedge core_clk_i);
            end
        end
    end
endmodule

// ---- tb/timer_event_flag_irq_bench.sv ----
// self-checking bench for the timer event flags and requests
module timer_event_flag_irq_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import timer_event_pkg::*;
    logic             core_clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             cen = 1'b0, cas = 1'b0, oie = 1'b0, dbg = 1'b0, serve = 1'b0;
    logic             ovf_rd, ovf_wr, ovf_wd, cdn, ovf, oirq;
    logic [15:0]      modv = 16'h0000, cnt;
    logic [1:0][3:0]  mode = '{CH_CAPTURE, CH_CAPTURE};
    logic [1:0]       eh = 2'h0, el = 2'h0, cie = 2'h0, pin = 2'h0;
    logic [1:0]       crd = 2'h0, cwr = 2'h0, cwd = 2'h0, cflag, cirq;
    logic [1:0][15:0] cval = '0, cap;
    int               n_fail = 0;
    int               checks = 0;

    timer_event_flag_irq timer_event_flag_irq_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .count_enable_i(cen), .center_align_select_i(cas),
        .overflow_irq_enable_i(oie), .modulo_i(modv), .background_debug_state_i(dbg), .ch_mode_i(mode),
        .edge_select_high_bit_i(eh), .edge_select_low_bit_i(el), .channel_irq_enable_i(cie),
        .ch_value_i(cval), .ch_pin_i(pin), .ovf_rd_i(ovf_rd), .ovf_wr_i(ovf_wr), .ovf_wr_data_i(ovf_wd),
        .ch_rd_i(crd), .ch_wr_i(cwr), .ch_wr_data_i(cwd), .count_o(cnt), .count_down_o(cdn),
        .overflow_flag_o(ovf), .channel_event_flag_o(cflag), .capture_o(cap), .overflow_irq_o(oirq),
        .channel_irq_o(cirq));
    irq_service_model irq_service_model_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .serve_i(serve), .irq_i(ovf),
        .rd_o(ovf_rd), .wr_o(ovf_wr), .wr_data_o(ovf_wd));

    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ch_clear(input int i);
        crd[i] = 1'b1;
        tick(1);
        crd[i] = 1'b0;
        cwr[i] = 1'b1;
        cwd[i] = 1'b0;
        tick(1);
        cwr[i] = 1'b0;
        tick(1);
    endtask
    task automatic wait_ovf(input logic v, input int lim);
        for (int k = 0; k < lim && ovf !== v; k++) tick(1);
    endtask
    task automatic ovf_clear();
        cen = 1'b0;
        serve = 1'b1;
        wait_ovf(1'b0, 20);
        serve = 1'b0;
        chk("ovf_cleared", 16'h0000, ovf);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_overflow();
        modv = 16'h0003;
        cen = 1'b1;
        wait_ovf(1'b1, 20);
        chk("ovf_mod", 16'h0001, ovf);
        chk("cnt_after_wrap", 16'h0001, 16'(cnt <= 16'h0001));
        chk("oirq_masked", 16'h0000, oirq);
        oie = 1'b1;
        tick(4);
        chk("oirq_level", 16'h0001, oirq);
        ovf_clear();
        chk("oirq_gone", 16'h0000, oirq);
        modv = 16'h0000;
        cen = 1'b1;
        wait_ovf(1'b1, 70000);
        chk("ovf_free", 16'h0001, ovf);
        chk("cnt_free_wrap", 16'h0001, 16'(cnt <= 16'h0001));
        ovf_clear();
        oie = 1'b0;
    endtask
    task automatic t_compare();
        mode[0] = CH_COMPARE;
        cval[0] = 16'h0002;
        modv = 16'h0005;
        cen = 1'b1;
        for (int k = 0; k < 20 && cflag[0] !== 1'b1; k++) tick(1);
        cen = 1'b0;
        chk("cmp_flag", 16'h0001, cflag[0]);
        chk("cmp_cnt", 16'h0001, 16'(cnt >= 16'h0002 && cnt <= 16'h0004));
        tick(2);
        cwr[0] = 1'b1;
        cwd[0] = 1'b1;
        tick(1);
        cwd[0] = 1'b0;
        tick(1);
        cwr[0] = 1'b0;
        tick(1);
        chk("flag_kept", 16'h0001, cflag[0]);
        cie[0] = 1'b1;
        tick(1);
        chk("cirq_on", 16'h0001, cirq[0]);
        chk("oirq_apart", 16'h0000, oirq);
        ch_clear(0);
        chk("cmp_cleared", 16'h0000, cflag[0]);
        chk("cirq_off", 16'h0000, cirq[0]);
        // edge pwm: flag at the duty match, counter one step past it
        mode[0] = CH_EPWM;
        cen = 1'b1;
        for (int k = 0; k < 20 && cflag[0] !== 1'b1; k++) tick(1);
        cen = 1'b0;
        chk("epwm_flag", 16'h0001, cflag[0]);
        chk("epwm_cnt", 16'h0001, 16'(cnt == 16'h0003));
        ch_clear(0);
    endtask
    task automatic t_edges();
        logic [1:0] s;
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            {eh[1], el[1]} = s;
            tick(5);
            pin[1] = 1'b1;
            tick(5);
            chk("rise_flag", 16'(s[0]), cflag[1]);
            ch_clear(1);
            pin[1] = 1'b0;
            tick(5);
            chk("fall_flag", 16'(s[1]), cflag[1]);
            ch_clear(1);
        end
    endtask
    task automatic t_lost_event();
        {eh[1], el[1]} = 2'h1;
        pin[1] = 1'b1;
        tick(5);
        crd[1] = 1'b1;
        tick(1);
        crd[1] = 1'b0;
        pin[1] = 1'b0;
        tick(2);
        pin[1] = 1'b1;
        tick(5);
        cwr[1] = 1'b1;
        tick(1);
        cwr[1] = 1'b0;
        tick(1);
        chk("flag_after_new_event", 16'h0001, cflag[1]);
        ch_clear(1);
        chk("flag_second_clear", 16'h0000, cflag[1]);
        pin[1] = 1'b0;
        tick(5);
    endtask
    task automatic t_debug();
        logic [15:0] held;
        cen = 1'b1;
        tick(4);
        dbg = 1'b1;
        tick(3);
        held = cnt;
        pin[1] = 1'b1;
        tick(5);
        chk("dbg_frozen", held, cnt);
        chk("dbg_capture", held, cap[1]);
        chk("dbg_flag", 16'h0001, cflag[1]);
        dbg = 1'b0;
        cen = 1'b0;
        ch_clear(1);
        pin[1] = 1'b0;
    endtask
    task automatic t_center();
        // earlier wraps left the overflow flag set
        ovf_clear();
        mode[0] = CH_CENTER_ALIGNED_PWM;
        modv = 16'h0004;
        cas = 1'b1;
        cen = 1'b1;
        wait_ovf(1'b1, 30);
        chk("ctr_ovf", 16'h0001, ovf);
        chk("ctr_cnt", 16'h0001, 16'(cnt >= 16'h0002 && cnt <= 16'h0004));
        chk("ctr_down", 16'h0001, cdn);
        chk("center_aligned_pwm_up_match", 16'h0001, cflag[0]);
        cen = 1'b0;
        tick(2);
        ch_clear(0);
        cen = 1'b1;
        for (int k = 0; k < 10 && cflag[0] !== 1'b1; k++) tick(1);
        chk("center_aligned_pwm_down_match", 16'h0001, cflag[0]);
        chk("center_aligned_pwm_down_dir", 16'h0001, cdn);
        ovf_clear();
    endtask

    initial begin
        tick(4);
        rst_n_i = 1'b1;
        tick(1);
        chk("rst_cnt", 16'h0000, cnt);
        chk("rst_flags", 16'h0000, {ovf, cflag, oirq});
        t_overflow();
        t_compare();
        t_edges();
        t_lost_event();
        t_debug();
        t_center();
        report_and_stop();
    end
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
endmodule
